// [logic/isoadc_sequencer.sv]
/*
  Converter sequencer behind the module bus: register file, settle and
  conversion timing, interrupt requests, identification space access.
  Assumes module bus strobes on core_clk and a converter whose parallel
  sample pins are stable at the end of the conversion time.
*/
// Notes on behaviour
// - Conversion within 10 us; 12.5 us including settle after channel or gain change.
// - An interrupt tells the host a new sample is ready.
// - Identification space accesses are answered after exactly one wait state.
// - I/O and interrupt acknowledge cycles are answered with zero wait states.
// - Multiplexer runs as sixteen single-ended or eight differential channels.
// - Four gains: 1, 2, 5, 10 on one variant, 1, 2, 4, 8 on other.
// - Calibration data for gain and offset sits readable in identification space.
// - Every result has twelve bits whatever the channel configuration.
// - With interrupts on, request 1 at settle end unless an automatic conversion is pending, request 0 at conversion end.
// - Twelve-bit result is left-justified in the sixteen-bit result register.
// - Bus reset clears control, result, status and start registers.
`timescale 1ns/1ps
module isoadc_sequencer import isoadc_pkg::*; #(
  parameter bit GAIN_DECADE = 1'b1,
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int CONV_CYCLES = CONV_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic io_sel_n,
  input wire logic id_sel_n,
  input wire logic int_sel_n,
  input wire logic bus_read,
  input wire logic [5:0] bus_addr,
  input wire logic [1:0] byte_sel_n,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_n,
  output logic ack_n,
  output logic int_req0_n,
  output logic int_req1_n,
  output logic [3:0] mux_chan,
  output logic mux_diff,
  output logic [1:0] pga_gain,
  output logic [3:0] pga_factor,
  output logic adc_start,
  input wire logic [SAMPLE_W-1:0] adc_sample,
  input wire logic cal_wr_en,
  input wire logic [ID_AW-1:0] cal_wr_addr,
  input wire logic [7:0] cal_wr_data
);
  isoadc_acc_t acc_state;
  isoadc_cv_t cv_state;
  logic [15:0] adc_control;
  logic [15:0] adc_result;
  logic [7:0] irq_vector;
  logic [SAMPLE_W-1:0] sample_meta;
  logic [SAMPLE_W-1:0] sample_sync;
  logic [SAMPLE_W-1:0] prev_sample;
  logic [CNT_W-1:0] cv_cnt;
  logic settle_pend;
  logic auto_pend;
  logic irq0_pend;
  logic irq1_pend;
  logic acc_read;
  logic [7:0] id_rdata;
  logic take;
  logic io_wr;
  logic ctl_wr;
  logic trig_wr;
  logic ack_cycle;
  logic [15:0] next_control;
  logic [15:0] io_rdata;
  logic [7:0] condition;

  function automatic logic is_word(input logic [5:0] a, input logic [6:0] ofs);
    is_word = (a == ofs[6:1]);
  endfunction

  function automatic logic [3:0] gain_factor(input logic [1:0] g);
    case (g)
      2'b00: gain_factor = 4'd1;
      2'b01: gain_factor = 4'd2;
      2'b10: gain_factor = GAIN_DECADE ? 4'd5 : 4'd4;
      default: gain_factor = GAIN_DECADE ? 4'd10 : 4'd8;
    endcase
  endfunction

  assign take = (acc_state == ACC_IDLE) && !(io_sel_n && id_sel_n && int_sel_n);
  assign io_wr = take && !io_sel_n && !bus_read;
  assign ack_cycle = take && io_sel_n && id_sel_n && !int_sel_n;
  assign ctl_wr = io_wr && is_word(bus_addr, OFS_CONTROL);
  assign trig_wr = io_wr && is_word(bus_addr, OFS_TRIGGER) && !byte_sel_n[0];

  always_comb begin
    next_control = adc_control;
    if (!byte_sel_n[1]) begin
      next_control[15:8] = data_in[15:8];
    end
    if (!byte_sel_n[0]) begin
      next_control[7:0] = data_in[7:0];
    end
  end

  assign condition = {6'h00, settle_pend || (cv_state == CV_SETTLE), cv_state == CV_CONV};

  always_comb begin
    io_rdata = 16'h0000;
    if (is_word(bus_addr, OFS_CONTROL)) begin
      io_rdata = {6'h00, adc_control[CTL_USED_MSB:0]};
    end else if (is_word(bus_addr, OFS_RESULT)) begin
      io_rdata = adc_result;
    end else if (is_word(bus_addr, OFS_CONDITION)) begin
      io_rdata = {8'h00, condition};
    end else if (is_word(bus_addr, OFS_VECTOR)) begin
      io_rdata = {8'h00, irq_vector};
    end
  end

  // Bus access sequencing
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      acc_state <= ACC_IDLE;
      acc_read <= 1'b0;
      data_out <= 16'h0000;
    end else begin
      case (acc_state)
        ACC_IDLE: begin
          if (take) begin
            acc_read <= bus_read || !int_sel_n;
            if (!id_sel_n) begin
              acc_state <= ACC_WAIT;
            end else begin
              acc_state <= ACC_ACK;
              data_out <= io_sel_n ? {8'h00, irq_vector} : io_rdata;
            end
          end
        end
        ACC_WAIT: begin
          acc_state <= ACC_ACK;
          data_out <= {8'h00, id_rdata};
        end
        ACC_ACK: acc_state <= ACC_END;
        ACC_END: begin
          if (io_sel_n && id_sel_n && int_sel_n) begin
            acc_state <= ACC_IDLE;
          end
        end
        default: acc_state <= ACC_IDLE;
      endcase
    end
  end

  assign ack_n = !(acc_state == ACC_ACK);
  assign data_oe_n = !((acc_state == ACC_ACK) && acc_read);

  isoadc_idmem u_idmem (
    .core_clk(core_clk),
    .rd_addr(bus_addr[ID_AW-1:0]),
    .rd_data(id_rdata),
    .wr_en(cal_wr_en),
    .wr_addr(cal_wr_addr),
    .wr_data(cal_wr_data)
  );

  // Register writes
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      adc_control <= CONTROL_RST;
      irq_vector <= VECTOR_RST;
    end else begin
      if (ctl_wr) begin
        adc_control <= next_control;
      end
      if (io_wr && is_word(bus_addr, OFS_VECTOR) && !byte_sel_n[0]) begin
        irq_vector <= data_in[7:0];
      end
    end
  end

  assign mux_diff = adc_control[CTL_DIFF];
  assign mux_chan = mux_diff ? {1'b0, adc_control[CTL_CHAN_LSB+2:CTL_CHAN_LSB]} :
                    adc_control[CTL_CHAN_LSB+3:CTL_CHAN_LSB];
  assign pga_gain = adc_control[CTL_GAIN_LSB+1:CTL_GAIN_LSB];
  assign pga_factor = gain_factor(pga_gain);

  // Sample pins cross from the isolated converter
  always_ff @(posedge core_clk) begin
    sample_meta <= adc_sample;
    sample_sync <= sample_meta;
  end

  // Settle and conversion sequencing
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cv_state <= CV_IDLE;
      cv_cnt <= '0;
      settle_pend <= 1'b0;
      auto_pend <= 1'b0;
      adc_start <= 1'b0;
      adc_result <= RESULT_RST;
      prev_sample <= '0;
    end else begin
      adc_start <= 1'b0;
      if (ctl_wr) begin
        if (next_control[CTL_GAIN_LSB+1:0] != adc_control[CTL_GAIN_LSB+1:0]) begin
          settle_pend <= 1'b1;
        end
        auto_pend <= next_control[CTL_AUTO];
      end
      if (io_wr && is_word(bus_addr, OFS_RESULT)) begin
        adc_result <= data_in;
      end
      case (cv_state)
        CV_IDLE: begin
          if (settle_pend && !ctl_wr) begin
            cv_state <= CV_SETTLE;
            settle_pend <= 1'b0;
            cv_cnt <= CNT_W'(SETTLE_CYCLES - 1);
          end else if ((auto_pend && !ctl_wr) || (trig_wr && !adc_control[CTL_AUTO])) begin
            cv_state <= CV_CONV;
            auto_pend <= 1'b0;
            adc_start <= 1'b1;
            cv_cnt <= CNT_W'(CONV_CYCLES - 1);
          end
        end
        CV_SETTLE: begin
          if (cv_cnt == '0) begin
            cv_state <= CV_IDLE;
          end else begin
            cv_cnt <= cv_cnt - 1'b1;
          end
        end
        CV_CONV: begin
          if (cv_cnt == '0) begin
            cv_state <= CV_IDLE;
            prev_sample <= sample_sync;
            if (adc_control[CTL_PIPE]) begin
              adc_result <= {prev_sample, RESULT_PAD'(0)};
            end else begin
              adc_result <= {sample_sync, RESULT_PAD'(0)};
            end
          end else begin
            cv_cnt <= cv_cnt - 1'b1;
          end
        end
        default: cv_state <= CV_IDLE;
      endcase
    end
  end

  // Interrupt requests; a new event wins over the acknowledge
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq0_pend <= 1'b0;
      irq1_pend <= 1'b0;
    end else begin
      if (ack_cycle) begin
        if (irq0_pend) begin
          irq0_pend <= 1'b0;
        end else begin
          irq1_pend <= 1'b0;
        end
      end
      if (cv_state == CV_CONV && cv_cnt == '0 && adc_control[CTL_INT_EN]) begin
        irq0_pend <= 1'b1;
      end
      if (cv_state == CV_SETTLE && cv_cnt == '0 && adc_control[CTL_INT_EN] && !auto_pend) begin
        irq1_pend <= 1'b1;
      end
    end
  end

  assign int_req0_n = !irq0_pend;
  assign int_req1_n = !irq1_pend;
endmodule // isoadc_sequencer

// [logic/isoadc_pkg.sv]
/*
  Shared constants of the isolated converter sequencer: register byte
  addresses, control and status field positions, state codes, timing.
  Assumes a 50 MHz core clock shared with the module bus.
*/
package isoadc_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETTLE_NS = 2500;
  localparam int CONV_NS = 10000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC = CONV_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 10;

  // Byte offsets on the I/O space, word index is offset bits 6:1
  localparam logic [6:0] OFS_CONTROL = 7'h00;
  localparam logic [6:0] OFS_RESULT = 7'h02;
  localparam logic [6:0] OFS_CONDITION = 7'h05;
  localparam logic [6:0] OFS_TRIGGER = 7'h07;
  localparam logic [6:0] OFS_VECTOR = 7'h09;

  // Control field positions
  localparam int CTL_CHAN_LSB = 0;
  localparam int CTL_DIFF = 4;
  localparam int CTL_GAIN_LSB = 5;
  localparam int CTL_AUTO = 7;
  localparam int CTL_PIPE = 8;
  localparam int CTL_INT_EN = 9;
  localparam int CTL_USED_MSB = 9;

  // Condition field positions
  localparam int STS_CONV_BUSY = 0;
  localparam int STS_SETTLE_BUSY = 1;

  // Reset values
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [7:0] VECTOR_RST = 8'h00;

  // Result layout
  localparam int SAMPLE_W = 12;
  localparam int RESULT_PAD = 4;

  // Identification space
  localparam int ID_DEPTH = 32;
  localparam int ID_HDR_LEN = 13;
  localparam int ID_AW = 5;

  typedef enum logic [3:0] {
    ACC_IDLE = 4'b0001,
    ACC_WAIT = 4'b0010,
    ACC_ACK = 4'b0100,
    ACC_END = 4'b1000
  } isoadc_acc_t;

  typedef enum logic [2:0] {
    CV_IDLE = 3'b001,
    CV_SETTLE = 3'b010,
    CV_CONV = 3'b100
  } isoadc_cv_t;
endpackage

// [logic/isoadc_idmem.sv]
/*
  Identification space memory: fixed header bytes followed by writable
  calibration bytes. Read data comes out of a register one cycle later.
  Assumes a factory port loads calibration bytes.
*/
`timescale 1ns/1ps
module isoadc_idmem import isoadc_pkg::*; #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] MODEL_CODE = 8'h33, // Arbitrary value
  parameter logic [7:0] REV_CODE = 8'h01, // Arbitrary value
  parameter logic [7:0] OPTION_CODE = 8'h01 // Arbitrary value
) (
  input wire logic core_clk,
  input wire logic [ID_AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic wr_en,
  input wire logic [ID_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data
);
  logic [7:0] cal_mem [ID_DEPTH];

  function automatic logic [7:0] hdr_byte(input logic [ID_AW-1:0] a);
    case (a)
      5'h00: hdr_byte = 8'h49;
      5'h01: hdr_byte = 8'h50;
      5'h02: hdr_byte = 8'h41;
      5'h03: hdr_byte = 8'h43;
      5'h04: hdr_byte = MAKER_CODE;
      5'h05: hdr_byte = MODEL_CODE;
      5'h06: hdr_byte = REV_CODE;
      5'h0a: hdr_byte = 8'h15;
      5'h0b: hdr_byte = 8'h00;
      5'h0c: hdr_byte = OPTION_CODE;
      default: hdr_byte = 8'h00;
    endcase
  endfunction

  always_ff @(posedge core_clk) begin
    if (wr_en && (wr_addr >= ID_AW'(ID_HDR_LEN))) begin
      cal_mem[wr_addr] <= wr_data;
    end
  end

  // Calibration bytes readable by the host
  always_ff @(posedge core_clk) begin
    rd_data <= (rd_addr < ID_AW'(ID_HDR_LEN)) ? hdr_byte(rd_addr) : cal_mem[rd_addr];
  end
endmodule // isoadc_idmem

// [sim/isoadc_chk_assertions.sv]
/*
  Checker of bus answer timing, mux and gain pins, start and done spacing.
  Assumes bind to isoadc_sequencer and selects held until answered.
*/
`timescale 1ns/1ps
module isoadc_chk_assertions #(
  parameter bit GAIN_DECADE = 1'b1,
  parameter int CONV_CYCLES = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic io_sel_n,
  input wire logic id_sel_n,
  input wire logic int_sel_n,
  input wire logic bus_read,
  input wire logic ack_n,
  input wire logic data_oe_n,
  input wire logic int_req0_n,
  input wire logic adc_start,
  input wire logic [3:0] mux_chan,
  input wire logic mux_diff,
  input wire logic [1:0] pga_gain,
  input wire logic [3:0] pga_factor
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [9:0] since_start;
  // Cycles since the last start pulse
  always_ff @(posedge core_clk) begin
    if (!reset_n || adc_start) since_start <= 10'h000;
    else if (since_start != 10'h3ff) since_start <= since_start + 10'h001;
  end
  sequence id_wait_s;
    ack_n ##1 !ack_n;
  endsequence
  io_zero_wait_a: assert property ($fell(io_sel_n) && id_sel_n && int_sel_n |=> !ack_n)
    else $error("io access not answered next cycle");
  int_zero_wait_a: assert property ($fell(int_sel_n) && io_sel_n && id_sel_n |=> !ack_n && !data_oe_n)
    else $error("int ack not answered next cycle");
  id_one_wait_a: assert property ($fell(id_sel_n) |=> id_wait_s)
    else $error("id access wait state wrong");
  ack_one_cycle_a: assert property (!ack_n |=> ack_n)
    else $error("ack longer than one cycle");
  read_drive_a: assert property (!ack_n && !io_sel_n |-> data_oe_n == !bus_read)
    else $error("data drive wrong in io cycle");
  diff_chan_a: assert property (mux_diff |-> !mux_chan[3])
    else $error("channel above eight in differential mode");
  gain_factor_a: assert property (pga_factor == (pga_gain == 2'b00 ? 4'h1 : pga_gain == 2'b01 ? 4'h2 :
    pga_gain == 2'b10 ? (GAIN_DECADE ? 4'h5 : 4'h4) : (GAIN_DECADE ? 4'ha : 4'h8)))
    else $error("gain factor mismatch");
  start_spacing_a: assert property (adc_start |=> (!adc_start)[*7])
    else $error("second start during busy");
  done_timing_a: assert property ($fell(int_req0_n) |-> since_start >= CONV_CYCLES - 2 &&
    since_start <= CONV_CYCLES + 3)
    else $error("conversion done at wrong time");
endmodule // isoadc_chk_assertions

// [sim/isoadc_conv_model.sv]
/*
  Converter model: latches the analog level at each start pulse.
  Assumes the sequencer samples its pins at the end of conversion.
*/
`timescale 1ns/1ps
module isoadc_conv_model (
  input wire logic core_clk,
  input wire logic adc_start,
  input wire logic [11:0] level,
  output logic [11:0] adc_sample
);
  always_ff @(posedge core_clk) begin
    if (adc_start) adc_sample <= level;
  end
endmodule // isoadc_conv_model

// [sim/tb_top.sv]
/*
  Self-checking bench of the converter sequencer against a reference model.
  Assumes the converter model on the sample pins and the bound checker.
*/
`timescale 1ns/1ps
module tb_top import isoadc_pkg::*;;
  logic core_clk = 1'b0, reset_n = 1'b0, io_sel_n = 1'b1, id_sel_n = 1'b1, int_sel_n = 1'b1;
  logic bus_read = 1'b1, cal_wr_en = 1'b0, data_oe_n, ack_n, int_req0_n, int_req1_n, mux_diff, adc_start;
  logic [5:0] bus_addr = 6'h00;
  logic [1:0] byte_sel_n = 2'b11, pga_gain;
  logic [15:0] data_in = 16'h0000, data_out, rd, ctrl, vec;
  logic [3:0] mux_chan, pga_factor;
  logic [11:0] adc_sample, level = 12'h000, lvl_prev = 12'h000;
  logic [4:0] cal_wr_addr = 5'h00;
  logic [7:0] cal_wr_data = 8'h00;
  int error_cnt = 0, check_count = 0, seed = 32'hdf92c77e, k, n;
  always #10 core_clk = ~core_clk;
  isoadc_sequencer #(.SETTLE_CYCLES(5), .CONV_CYCLES(8)) i_isoadc_sequencer (.core_clk, .reset_n, .io_sel_n,
    .id_sel_n, .int_sel_n, .bus_read, .bus_addr, .byte_sel_n, .data_in, .data_out, .data_oe_n, .ack_n,
    .int_req0_n, .int_req1_n, .mux_chan, .mux_diff, .pga_gain, .pga_factor, .adc_start, .adc_sample,
    .cal_wr_en, .cal_wr_addr, .cal_wr_data);
  isoadc_conv_model i_isoadc_conv_model (.core_clk, .adc_start, .level, .adc_sample);
  function automatic logic [3:0] fac(input logic [1:0] g);
    fac = (g == 2'b11) ? 4'ha : (g == 2'b10) ? 4'h5 : {2'b00, g} + 4'h1;
  endfunction
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Kind 0 io, 1 id, 2 int ack
  task automatic acc(input int kind, input logic rdn, input logic [5:0] a, input logic [15:0] d);
    @(negedge core_clk);
    bus_read = rdn;
    bus_addr = a;
    data_in = rdn ? 16'($random(seed)) : d;
    byte_sel_n = 2'b00;
    if (kind == 0) io_sel_n = 1'b0;
    else if (kind == 1) id_sel_n = 1'b0;
    else int_sel_n = 1'b0;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (ack_n !== 1'b0 && n < 20);
    chk((kind == 1) ? 16'h0002 : 16'h0001, 16'(n));
    rd = data_out;
    @(negedge core_clk);
    {io_sel_n, id_sel_n, int_sel_n} = 3'b111;
    byte_sel_n = 2'b11;
    @(negedge core_clk);
  endtask
  task automatic wait_req0();
    for (k = 0; k < 100 && int_req0_n !== 1'b0; k++) @(negedge core_clk);
    chk(16'h0000, {15'h0, int_req0_n});
  endtask
  initial begin
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    for (k = 0; k < 6; k++) begin
      acc(0, 1, k[5:0], 16'h0000);
      chk(16'h0000, rd);
    end
    $display("reset values done");
    for (k = 0; k < 8; k++) begin
      ctrl = (16'($random(seed)) & 16'hfc0f) | 16'(k << 4);
      acc(0, 0, 6'h00, ctrl);
      acc(0, 1, 6'h00, 16'h0000);
      chk(ctrl & 16'h03ff, rd);
      chk({11'h0, ctrl[4], ctrl[3:0] & {~ctrl[4], 3'b111}}, {11'h0, mux_diff, mux_chan});
      chk({12'h0, fac(ctrl[6:5])}, {12'h0, pga_factor});
    end
    $display("mux and gain done");
    for (k = 13; k < 32; k++) begin
      cal_wr_data = 8'($random(seed));
      cal_wr_addr = k[4:0];
      cal_wr_en = 1'b1;
      @(negedge core_clk);
      cal_wr_en = 1'b0;
      acc(1, 1, k[5:0], 16'h0000);
      chk({8'h00, cal_wr_data}, rd);
    end
    vec = 16'($random(seed)) & 16'h00ff;
    acc(0, 0, 6'h04, vec);
    $display("id space done");
    // Mode 0 triggered, 1 automatic, 2 automatic with pipeline
    for (int m = 0; m < 3; m++) begin
      lvl_prev = level;
      level = 12'($random(seed));
      ctrl = 16'h0203 | ((m != 0) ? 16'h0080 : 16'h0000) | ((m == 2) ? 16'h0100 : 16'h0000) | 16'((m + 1) << 5);
      acc(0, 0, 6'h00, ctrl);
      if (m == 0) begin
        for (k = 0; k < 100 && int_req1_n !== 1'b0; k++) @(negedge core_clk);
        chk(16'h0000, {15'h0, int_req1_n});
        acc(2, 1, 6'h00, 16'h0000);
        chk(vec, rd);
        acc(0, 0, 6'h03, 16'h0000);
        acc(0, 1, 6'h02, 16'h0000);
        chk(16'h0001, rd & 16'h0001);
      end
      wait_req0();
      chk(16'h0001, {15'h0, int_req1_n});
      acc(2, 1, 6'h00, 16'h0000);
      acc(0, 1, 6'h01, 16'h0000);
      chk({(m == 2) ? lvl_prev : level, 4'h0}, rd);
      $display("conversion mode %0d done", m);
    end
    acc(0, 0, 6'h00, ctrl);
    reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    for (k = 0; k < 3; k++) begin
      acc(0, 1, k[5:0], 16'h0000);
      chk(16'h0000, rd);
    end
    repeat (20) @(negedge core_clk);
    chk(16'h0001, {15'h0, int_req0_n});
    $display("mid-run reset done");
    end_of_test();
  end
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end
endmodule // tb_top
bind isoadc_sequencer isoadc_chk_assertions #(.GAIN_DECADE(GAIN_DECADE), .CONV_CYCLES(CONV_CYCLES))
  i_isoadc_chk_assertions (.core_clk, .reset_n, .io_sel_n, .id_sel_n, .int_sel_n, .bus_read, .ack_n,
  .data_oe_n, .int_req0_n, .adc_start, .mux_chan, .mux_diff, .pga_gain, .pga_factor);
